// File: logic/mws_pkg.sv
package mws_pkg;

    // ==========================================================
    // Coprocessor register selectors
    // ==========================================================
    localparam logic [3:0] CRN_BASE    = 4'h2;  // Base registers and base-select control
    localparam logic [3:0] CRN_DOMAIN  = 4'h3;  // Domain permission register
    localparam logic [3:0] CRN_FAULT   = 4'h5;  // Fault status registers
    localparam logic [3:0] CRM_ZERO    = 4'h0;  // Secondary selector for all of ours
    localparam logic [2:0] OP2_BASE0   = 3'h0;  // First translation base
    localparam logic [2:0] OP2_BASE1   = 3'h1;  // Second translation base
    localparam logic [2:0] OP2_SELCTL  = 3'h2;  // Base-select control
    localparam logic [2:0] OP2_DOMAIN  = 3'h0;  // Domain permission
    localparam logic [2:0] OP2_DFAULT  = 3'h0;  // Data fault status
    localparam logic [2:0] OP2_IFAULT  = 3'h1;  // Instruction fault status

    // ==========================================================
    // Field positions, masks and reset values
    // ==========================================================
    localparam int         SEL_PD1_BIT = 5;          // walk_disable_base1
    localparam int         SEL_PD0_BIT = 4;          // walk_disable_base0
    localparam int         FS_EXT_BIT  = 12;         // External abort qualifier
    localparam int         FS_WNR_BIT  = 11;         // Access direction flag
    localparam int         FS_HI_BIT   = 10;         // Fault code high bit
    localparam int         FS_DOM_LSB  = 4;          // Domain field [7:4]
    localparam logic [31:0] SEL_MASK   = 32'h0000_0037;
    localparam logic [31:0] DFS_MASK   = 32'h0000_1cff;
    localparam logic [31:0] IFS_MASK   = 32'h0000_140f;
    localparam logic [31:0] SEL_RESET  = 32'h0000_0000;
    localparam logic [31:0] DOM_RESET  = 32'h0000_0000;
    localparam logic [31:0] FS_RESET   = 32'h0000_0000;
    localparam logic [24:0] BASE_RESET = 25'h000_0000;
    localparam int          NUM_CAUSE  = 15;         // Fault causes, index 0 highest

    // Five-bit fault code per cause, in priority order (x bits shown as 0)
    localparam logic [14:0][4:0] CAUSE_CODE = {
        5'h02, 5'h16, 5'h08, 5'h0f, 5'h0d, 5'h0b, 5'h09, 5'h06,
        5'h03, 5'h07, 5'h05, 5'h0e, 5'h0c, 5'h04, 5'h01};
    // Causes whose code takes the bus-error qualifier
    localparam logic [14:0] CAUSE_EXT  = 15'h300c;
    localparam int          CAUSE_SECT = 4;          // Section translation fault

    // Domain permission field values
    localparam logic [1:0] DOM_NONE    = 2'h0;
    localparam logic [1:0] DOM_CLIENT  = 2'h1;
    localparam logic [1:0] DOM_MANAGER = 2'h3;

    // ==========================================================
    // Carriers
    // ==========================================================
    typedef struct packed {
        logic        valid;     // One-cycle access strobe
        logic        write;     // Write instruction when set
        logic [3:0]  crn;       // Primary register number
        logic [3:0]  secondary_register_selector;       // secondary_register_selector
        logic [2:0]  op2;       // Opcode-2 selector
        logic [31:0] wdata;     // Write data
        logic        secure;    // Secure state
        logic        priv;      // Privileged mode
    } mws_cp_req_type;

    typedef struct packed {
        logic        valid;     // TLB miss strobe
        logic [31:0] va;        // Missing virtual address
        logic        secure;    // Security state of the access
    } mws_miss_type;

    typedef struct packed {
        logic        valid;     // Domain check strobe
        logic        secure;    // Selects the bank
        logic [3:0]  domain;    // Domain of the entry
        logic        perm_fail; // TLB permission bits would refuse
        logic        xn_exec;   // Fetch from execute_never_attr page
    } mws_check_type;

    typedef struct packed {
        logic        valid;     // Abort strobe
        logic        instr;     // Prefetch abort when set
        logic        secure;    // Bank to record into
        logic [14:0] causes;    // Coinciding causes, bit 0 highest
        logic        write;     // Faulting access was a write
        logic        cp_op;     // Aborted coprocessor operation
        logic [3:0]  domain;    // Domain being accessed
        logic        slverr;    // Bus answered slave error
    } mws_abort_type;

endpackage

// File: logic/mws_mmu_ctrl.sv
`timescale 1ns/1ps
// Notes on behaviour
// (RQ1) Base1 walk disabled: section fault, no walk
// (RQ2) Base0 walk disabled: section fault, no walk
// (RQ3) Walk enabled: walk in current security state
// (RQ4) Boundary field: 16KB at 0 to 128B
// (RQ5) Base0 when N zero or top bits zero
// (RQ6) Secure write-disable blocks secure control writes
// (RQ7) Banked copies; user access is undefined
// (RQ8) Walks may look up level-one cache
// (RQ9) Sixteen two-bit domain permission fields
// (RQ10) Fields 00 and 10 give domain fault
// (RQ11) Client checks permissions; manager skips them
// (RQ12) Data abort overwrites data fault status
// (RQ13) Bit 12 bus error, external only
// (RQ14) Bit 11 direction; set on coprocessor abort
// (RQ15) Bits 7:4 hold faulting domain
// (RQ16) Code is bit 10 with bits 3:0
// (RQ17) Highest priority coincident fault is reported
// (RQ18) Lower priority fault codes in fixed order
// (RQ19) Data status at register 5, selectors zero
// (RQ20) Write loads data status for restore
// (RQ21) Prefetch abort records instruction fault status
// (RQ22) Instruction bit 12 qualifier, bit 11 zero
// (RQ23) Base0 keeps 31:7, walk uses N bits
// (RQ24) Reserved bits read zero, ignore writes
module mws_mmu_ctrl (
    input  wire logic                    core_clk,
    input  wire logic                    srst,
    input  wire mws_pkg::mws_cp_req_type cp_req,
    input  wire logic                    secure_write_disable_input,
    input  wire mws_pkg::mws_miss_type   miss,
    input  wire mws_pkg::mws_check_type  check,
    input  wire mws_pkg::mws_abort_type  abort_in,
    output logic                         cp_ack,
    output logic                         cp_undef,
    output logic [31:0]                  cp_rdata,
    output logic                         walk_start,
    output logic                         walk_base_sel,
    output logic [24:0]                  walk_table_base,
    output logic                         walk_secure,
    output logic                         walk_l1_lookup,
    output logic                         walk_denied,
    output logic                         check_done,
    output logic                         domain_fault,
    output logic                         perm_fault
);

    // ==========================================================
    // State
    // ==========================================================
    // Bank index 1 is the secure copy, 0 the non-secure copy
    typedef struct packed {
        logic             sdis_meta;   // Synchroniser first stage
        logic             sdis_sync;   // Synchronised write disable
        logic [1:0][31:0] selctl;      // Base-select control per bank
        logic [1:0][31:0] dom;         // Domain permission per bank
        logic [1:0][24:0] base0;       // First base bits 31:7
        logic [1:0][24:0] base1;       // Second base bits 31:7
        logic [1:0][31:0] dfs;         // Data fault status per bank
        logic [1:0][31:0] ifs;         // Instruction fault status per bank
        logic             ack;         // Access answer strobe
        logic             undef;       // Undefined instruction answer
        logic [31:0]      rdata;       // Read data
        logic             wstart;      // Walk launch strobe
        logic             wsel;        // Base used by the walk
        logic [24:0]      wbase;       // Masked table base
        logic             wsec;        // Walk security state
        logic             wl1;         // Walk may use level-one cache
        logic             wdeny;       // Walk suppressed, section fault
        logic             cdone;       // Domain check answer strobe
        logic             dfault;      // Domain fault result
        logic             pfault;      // Permission fault result
    } mws_state_type;

    mws_state_type state_reg;   // Registered state
    mws_state_type state_next;  // Next state

    // ==========================================================
    // Combinational helpers
    // ==========================================================
    logic       req_bank;       // Bank chosen by requester
    logic       hit_base0;      // Address decode hits
    logic       hit_base1;
    logic       hit_selctl;
    logic       hit_dom;
    logic       hit_dfs;
    logic       hit_ifs;
    logic       hit_any;
    logic       sdis_block;     // Secure write refused
    logic       miss_bank;
    logic [2:0] miss_n;         // Boundary-size field of that bank
    logic [31:0] top_mask;      // Virtual address bits 31:32-N
    logic       use_base1;      // Second base selected
    logic       walk_off;       // Chosen base has walk disabled
    logic [24:0] base_mask;     // Address bits used by the walk
    logic [1:0] dom_field;      // Permission field of checked domain
    logic [3:0] cause_idx;      // Winning fault cause
    logic [4:0] cause_fs;       // Its five-bit code
    logic       cause_ext;      // Its code takes the qualifier
    logic [31:0] fs_word;       // Assembled fault status word

    assign req_bank  = cp_req.secure;
    assign miss_bank = miss.secure;

    // ----------------------------------------------------------
    // Register decode; opcode-2 and secondary selector both count
    // ----------------------------------------------------------
    always_comb begin
        hit_base0  = 1'b0;
        hit_base1  = 1'b0;
        hit_selctl = 1'b0;
        hit_dom    = 1'b0;
        hit_dfs    = 1'b0;
        hit_ifs    = 1'b0;
        if (cp_req.crn == mws_pkg::CRN_BASE && cp_req.secondary_register_selector == mws_pkg::CRM_ZERO
            && cp_req.op2 == mws_pkg::OP2_BASE0) begin
            hit_base0 = 1'b1;
        end else if (cp_req.crn == mws_pkg::CRN_BASE && cp_req.secondary_register_selector == mws_pkg::CRM_ZERO
            && cp_req.op2 == mws_pkg::OP2_BASE1) begin
            hit_base1 = 1'b1;
        end else if (cp_req.crn == mws_pkg::CRN_BASE && cp_req.secondary_register_selector == mws_pkg::CRM_ZERO
            && cp_req.op2 == mws_pkg::OP2_SELCTL) begin
            hit_selctl = 1'b1;
        end else if (cp_req.crn == mws_pkg::CRN_DOMAIN && cp_req.secondary_register_selector == mws_pkg::CRM_ZERO
            && cp_req.op2 == mws_pkg::OP2_DOMAIN) begin
            hit_dom = 1'b1;
        end else if (cp_req.crn == mws_pkg::CRN_FAULT && cp_req.secondary_register_selector == mws_pkg::CRM_ZERO
            && cp_req.op2 == mws_pkg::OP2_DFAULT) begin
            hit_dfs = 1'b1; // RQ19
        end else if (cp_req.crn == mws_pkg::CRN_FAULT && cp_req.secondary_register_selector == mws_pkg::CRM_ZERO
            && cp_req.op2 == mws_pkg::OP2_IFAULT) begin
            hit_ifs = 1'b1; // RQ21
        end
    end

    assign hit_any = hit_base0 | hit_base1 | hit_selctl | hit_dom | hit_dfs | hit_ifs;

    // Secure copies of control and domain registers lock on the pin
    assign sdis_block = cp_req.write && cp_req.secure && state_reg.sdis_sync
        && (hit_selctl || hit_dom); // RQ6

    // ----------------------------------------------------------
    // Base selection for a missing address
    // ----------------------------------------------------------
    assign miss_n   = state_reg.selctl[miss_bank][2:0]; // RQ4
    assign top_mask = ~(32'hffff_ffff >> miss_n);
    // N of zero gives an empty mask, so base0 always wins
    assign use_base1 = (miss.va & top_mask) != 32'h0000_0000; // RQ5
    assign walk_off  = use_base1 ? state_reg.selctl[miss_bank][mws_pkg::SEL_PD1_BIT]
                                 : state_reg.selctl[miss_bank][mws_pkg::SEL_PD0_BIT];
    // Base0 drops 7-N low stored bits; base1 always spans 16KB
    assign base_mask = use_base1 ? (25'h1ff_ffff << 7)
                                 : (25'h1ff_ffff << (3'h7 - miss_n)); // RQ23

    // ----------------------------------------------------------
    // Domain field lookup
    // ----------------------------------------------------------
    assign dom_field = state_reg.dom[check.secure][{check.domain, 1'b0} +: 2]; // RQ9

    // ----------------------------------------------------------
    // Fault priority: lowest set cause index wins
    // ----------------------------------------------------------
    always_comb begin
        cause_idx = 4'h0;
        for (int i = mws_pkg::NUM_CAUSE - 1; i >= 0; i--) begin
            if (abort_in.causes[i]) begin
                cause_idx = 4'(i); // RQ17 RQ18
            end
        end
    end

    assign cause_fs  = mws_pkg::CAUSE_CODE[cause_idx];
    assign cause_ext = mws_pkg::CAUSE_EXT[cause_idx];

    // Status word shared by both records, direction added for data only
    always_comb begin
        fs_word = 32'h0000_0000;
        fs_word[mws_pkg::FS_HI_BIT] = cause_fs[4]; // RQ16
        fs_word[3:0] = cause_fs[3:0];
        fs_word[mws_pkg::FS_EXT_BIT] = cause_ext & abort_in.slverr; // RQ13 RQ22
        if (!abort_in.instr) begin
            fs_word[mws_pkg::FS_WNR_BIT] = abort_in.write | abort_in.cp_op; // RQ14
            fs_word[7:4] = abort_in.domain; // RQ15
        end
    end

    // ==========================================================
    // Next-state process
    // ==========================================================
    always_comb begin
        state_next = state_reg;
        // Two-stage capture of the asynchronous disable pin
        state_next.sdis_meta = secure_write_disable_input;
        state_next.sdis_sync = state_reg.sdis_meta;
        // Strobes default low
        state_next.ack    = 1'b0;
        state_next.undef  = 1'b0;
        state_next.rdata  = 32'h0000_0000;
        state_next.wstart = 1'b0;
        state_next.wdeny  = 1'b0;
        state_next.cdone  = 1'b0;
        state_next.dfault = 1'b0;
        state_next.pfault = 1'b0;

        // Coprocessor access, answered one cycle later
        if (cp_req.valid) begin
            state_next.ack = 1'b1;
            if (!cp_req.priv || !hit_any || sdis_block) begin
                // User mode, unmapped or locked: undefined, nothing stored
                state_next.undef = 1'b1; // RQ6 RQ7
            end else if (cp_req.write) begin
                // Reserved positions are masked away on write
                if (hit_base0) begin
                    state_next.base0[req_bank] = cp_req.wdata[31:7]; // RQ23
                end else if (hit_base1) begin
                    state_next.base1[req_bank] = cp_req.wdata[31:7];
                end else if (hit_selctl) begin
                    state_next.selctl[req_bank] = cp_req.wdata & mws_pkg::SEL_MASK; // RQ24
                end else if (hit_dom) begin
                    state_next.dom[req_bank] = cp_req.wdata; // RQ9
                end else if (hit_dfs) begin
                    state_next.dfs[req_bank] = cp_req.wdata & mws_pkg::DFS_MASK; // RQ20
                end else begin
                    state_next.ifs[req_bank] = cp_req.wdata & mws_pkg::IFS_MASK; // RQ24
                end
            end else begin
                // Reads return the selected bank's copy
                if (hit_base0) begin
                    state_next.rdata = {state_reg.base0[req_bank], 7'h00};
                end else if (hit_base1) begin
                    state_next.rdata = {state_reg.base1[req_bank], 7'h00};
                end else if (hit_selctl) begin
                    state_next.rdata = state_reg.selctl[req_bank];
                end else if (hit_dom) begin
                    state_next.rdata = state_reg.dom[req_bank];
                end else if (hit_dfs) begin
                    state_next.rdata = state_reg.dfs[req_bank]; // RQ19
                end else begin
                    state_next.rdata = state_reg.ifs[req_bank];
                end
            end
        end

        // TLB miss: walk or refuse with a section fault
        if (miss.valid) begin
            state_next.wsel  = use_base1;
            state_next.wbase = (use_base1 ? state_reg.base1[miss_bank]
                                          : state_reg.base0[miss_bank]) & base_mask;
            state_next.wsec  = miss.secure;
            if (walk_off) begin
                state_next.wdeny = 1'b1; // RQ1 RQ2
            end else begin
                state_next.wstart = 1'b1; // RQ3
                // Walks read through the level-one cache
                state_next.wl1    = 1'b1; // RQ8
            end
        end

        // Domain permission check
        if (check.valid) begin
            state_next.cdone = 1'b1;
            if (dom_field == mws_pkg::DOM_NONE || dom_field[0] == 1'b0) begin
                state_next.dfault = 1'b1; // RQ10
            end else if (dom_field == mws_pkg::DOM_CLIENT) begin
                state_next.pfault = check.perm_fail | check.xn_exec; // RQ11
            end
        end

        // Aborts come last so a fault beats a same-cycle software write
        if (abort_in.valid && abort_in.causes != 15'h0000) begin
            if (abort_in.instr) begin
                state_next.ifs[abort_in.secure] = fs_word & mws_pkg::IFS_MASK; // RQ21 RQ22
            end else begin
                state_next.dfs[abort_in.secure] = fs_word; // RQ12
            end
        end
    end

    // ==========================================================
    // State register
    // ==========================================================
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_reg           <= '0;
            state_reg.selctl[0] <= mws_pkg::SEL_RESET;
            state_reg.selctl[1] <= mws_pkg::SEL_RESET;
            state_reg.dom[0]    <= mws_pkg::DOM_RESET;
            state_reg.dom[1]    <= mws_pkg::DOM_RESET;
            state_reg.base0[0]  <= mws_pkg::BASE_RESET;
            state_reg.base0[1]  <= mws_pkg::BASE_RESET;
            state_reg.dfs[0]    <= mws_pkg::FS_RESET;
            state_reg.dfs[1]    <= mws_pkg::FS_RESET;
            state_reg.ifs[0]    <= mws_pkg::FS_RESET;
            state_reg.ifs[1]    <= mws_pkg::FS_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from the state register
    assign cp_ack          = state_reg.ack;
    assign cp_undef        = state_reg.undef;
    assign cp_rdata        = state_reg.rdata;
    assign walk_start      = state_reg.wstart;
    assign walk_base_sel   = state_reg.wsel;
    assign walk_table_base = state_reg.wbase;
    assign walk_secure     = state_reg.wsec;
    assign walk_l1_lookup  = state_reg.wl1;
    assign walk_denied     = state_reg.wdeny;
    assign check_done      = state_reg.cdone;
    assign domain_fault    = state_reg.dfault;
    assign perm_fault      = state_reg.pfault;

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    user_undef_a: assert property ( // RQ7
        cp_req.valid && !cp_req.priv |=> cp_ack && cp_undef && cp_rdata == 32'h0)
        else $error("user access not refused");

    sdis_lock_a: assert property ( // RQ6
        cp_req.valid && cp_req.write && cp_req.priv && sdis_block
        |=> cp_undef && $stable(state_reg.selctl[1]) && $stable(state_reg.dom[1]))
        else $error("locked secure write went through");

    skip_base1_a: assert property ( // RQ1
        miss.valid && use_base1 && state_reg.selctl[miss.secure][mws_pkg::SEL_PD1_BIT]
        |=> walk_denied && !walk_start && walk_base_sel)
        else $error("base1 walk not suppressed");

    skip_base0_a: assert property ( // RQ2
        miss.valid && !use_base1 && state_reg.selctl[miss.secure][mws_pkg::SEL_PD0_BIT]
        |=> walk_denied && !walk_start && !walk_base_sel)
        else $error("base0 walk not suppressed");

    walk_go_a: assert property ( // RQ3
        miss.valid && !walk_off |=> walk_start && walk_l1_lookup
        && walk_secure == $past(miss.secure))
        else $error("walk not launched");

    n_zero_sel_a: assert property ( // RQ5
        miss.valid && state_reg.selctl[miss.secure][2:0] == 3'h0 |=> !walk_base_sel)
        else $error("base1 used with zero boundary");

    dom_fault_a: assert property ( // RQ10
        check.valid && dom_field[0] == 1'b0 |=> check_done && domain_fault && !perm_fault)
        else $error("domain fault missing");

    manager_a: assert property ( // RQ11
        check.valid && dom_field == mws_pkg::DOM_MANAGER |=> !domain_fault && !perm_fault)
        else $error("manager access faulted");

    cp_wnr_a: assert property ( // RQ14
        abort_in.valid && !abort_in.instr && abort_in.cp_op && abort_in.causes != 15'h0
        |=> state_reg.dfs[$past(abort_in.secure)][mws_pkg::FS_WNR_BIT])
        else $error("coprocessor abort not marked write");

    ifs_bit11_a: assert property ( // RQ22
        ##1 state_reg.ifs[0][mws_pkg::FS_WNR_BIT] == 1'b0
        && state_reg.ifs[1][mws_pkg::FS_WNR_BIT] == 1'b0)
        else $error("instruction status bit 11 set");

    ext_only_a: assert property ( // RQ13
        abort_in.valid && !abort_in.instr && abort_in.causes[0]
        |=> !state_reg.dfs[$past(abort_in.secure)][mws_pkg::FS_EXT_BIT]
        && !state_reg.dfs[$past(abort_in.secure)][mws_pkg::FS_HI_BIT]
        && state_reg.dfs[$past(abort_in.secure)][3:0] == 4'h1)
        else $error("alignment fault recorded wrong");

    cov_denied_c: cover property (miss.valid ##1 walk_denied);
    cov_walk_c:   cover property (miss.valid && use_base1 ##1 walk_start);
    cov_dabort_c: cover property (abort_in.valid && !abort_in.instr ##2 cp_req.valid);
    cov_undef_c:  cover property (cp_undef);

endmodule

// File: dv/mws_core_model.sv
`timescale 1ns/1ps
// Core side: one coprocessor access at a time
module mws_core_model (
    input  wire logic               core_clk,
    output mws_pkg::mws_cp_req_type cp_req
);
    initial cp_req = '0;
    // Valid stands one edge; data flipped on release so stale values never pass
    task automatic access(input logic w, input logic [3:0] crn, input logic [2:0] op2,
                          input logic [31:0] wd, input logic s, input logic p);
        @(posedge core_clk) #1 cp_req = '{1'b1, w, crn, 4'h0, op2, wd, s, p};
        @(posedge core_clk) #1 cp_req.valid = 1'b0;
        cp_req.wdata = ~wd;
    endtask
endmodule

// File: dv/mws_mmu_ctrl_tb_top.sv
`timescale 1ns/1ps
module mws_mmu_ctrl_tb_top;
    logic core_clk, srst, swd, ack, undef, st, sel, sec, l1, den, done, df, pf;
    logic [31:0] rd;
    logic [24:0] wtb;
    mws_pkg::mws_cp_req_type cp_req;
    mws_pkg::mws_miss_type miss;
    mws_pkg::mws_check_type check;
    mws_pkg::mws_abort_type abort_in;
    int err_count = 0;
    int compares = 0;
    mws_core_model mws_core_model_inst (.core_clk(core_clk), .cp_req(cp_req));
    mws_mmu_ctrl mws_mmu_ctrl_inst (.core_clk(core_clk), .srst(srst), .cp_req(cp_req),
        .secure_write_disable_input(swd), .miss(miss), .check(check), .abort_in(abort_in),
        .cp_ack(ack), .cp_undef(undef), .cp_rdata(rd), .walk_start(st), .walk_base_sel(sel),
        .walk_table_base(wtb), .walk_secure(sec), .walk_l1_lookup(l1), .walk_denied(den),
        .check_done(done), .domain_fault(df), .perm_fault(pf));
    initial begin core_clk = 0; forever #12.5 core_clk = ~core_clk; end
    // ==========================================================
    // Shared helpers
    // ==========================================================
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        compares++;
        if (s !== e) begin err_count++; $display("[FAIL] %s exp %h got %h", n, e, s); end
    endtask
    // Access, then judge the answer in its one-cycle slot
    task automatic cp(input logic w, input logic [3:0] c, input logic [2:0] o,
                      input logic [31:0] wd, input logic s, input logic p, input logic u);
        mws_core_model_inst.access(w, c, o, wd, s, p);
        chk("ack_undef", {30'h0, 1'b1, u}, {30'h0, ack, undef});
    endtask
    task automatic go_miss(input logic [31:0] va, input logic s);
        @(posedge core_clk) #1 miss = '{1'b1, va, s};
        @(posedge core_clk) #1 miss.valid = 1'b0;
    endtask
    // Reads are flagged as aborted coprocessor operations, so bit 11 sees both sources
    task automatic ab(input logic i, input logic [14:0] c, input logic w, input logic [3:0] d);
        @(posedge core_clk) #1 abort_in = '{1'b1, i, 1'b0, c, w, ~w, d, 1'b1};
        @(posedge core_clk) #1 abort_in.valid = 1'b0;
    endtask
    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic t_select();
        cp(1, 4'h2, 3'h2, 32'hffff_ff12, 0, 1, 0);
        cp(0, 4'h2, 3'h2, 0, 0, 1, 0);
        chk("selctl", 32'h12, rd);
        cp(1, 4'h2, 3'h0, 32'hffff_ffff, 0, 1, 0);
        cp(0, 4'h2, 3'h0, 0, 0, 1, 0);
        chk("base0", 32'hffff_ff80, rd);
        cp(1, 4'h2, 3'h1, 32'h8000_4000, 0, 1, 0);
        go_miss(32'h2000_0000, 0);
        chk("miss_lo", 32'h4, {27'h0, l1, st, den, sel, sec});
        chk("base_lo", 32'h1ff_ffe0, {7'h0, wtb});
        go_miss(32'h4000_0000, 0);
        chk("miss_hi", 32'h1a, {27'h0, l1, st, den, sel, sec});
        chk("base_hi", 32'h100_0080, {7'h0, wtb});
        // Secure bank still has a zero boundary, so base0 serves the same address
        go_miss(32'h4000_0000, 1);
        chk("miss_sec", 32'h19, {27'h0, l1, st, den, sel, sec});
        cp(1, 4'h2, 3'h2, 32'h0000_0022, 0, 1, 0);
        go_miss(32'h4000_0000, 0);
        chk("miss_pd1", 32'h16, {27'h0, l1, st, den, sel, sec});
    endtask
    // Fields 00, 01, 10, 11 on domains 0 to 3, permission bits refusing
    task automatic t_domain();
        cp(1, 4'h3, 3'h0, 32'h0000_00e4, 0, 1, 0);
        for (int d = 0; d < 4; d++) begin
            @(posedge core_clk) #1 check = '{1'b1, 1'b0, d[3:0], 1'b1, 1'b0};
            @(posedge core_clk) #1 check.valid = 1'b0;
            chk("dom", {29'h0, 1'b1, d[0] == 0, d == 1}, {29'h0, done, df, pf});
        end
    endtask
    // Pin high blocks the secure write only; user and unmapped refused
    task automatic t_secure();
        swd = 1;
        repeat (3) @(posedge core_clk);
        cp(1, 4'h3, 3'h0, 32'h5555_5555, 1, 1, 1);
        cp(0, 4'h3, 3'h0, 0, 1, 1, 0);
        chk("dom_s", 32'h0, rd);
        cp(0, 4'h3, 3'h0, 0, 0, 1, 0);
        chk("dom_ns", 32'he4, rd);
        cp(0, 4'h5, 3'h0, 0, 0, 0, 1);
        cp(0, 4'h7, 3'h0, 0, 0, 1, 1);
        swd = 0;
    endtask
    task automatic t_abort();
        ab(0, 15'h1110, 1, 4'h5);
        cp(0, 4'h5, 3'h0, 0, 0, 1, 0);
        chk("dfs1", 32'h855, rd);
        ab(0, 15'h000d, 1, 4'h9);
        cp(0, 4'h5, 3'h0, 0, 0, 1, 0);
        chk("dfs_al", 32'h891, rd);
        ab(0, 15'h2000, 0, 4'h2);
        cp(0, 4'h5, 3'h0, 0, 0, 1, 0);
        chk("dfs2", 32'h1c26, rd);
        ab(1, 15'h0004, 1, 4'h7);
        cp(0, 4'h5, 3'h1, 0, 0, 1, 0);
        chk("ifs", 32'h100c, rd);
        // Restore path written as read-modify-write, every stored bit inverted
        cp(0, 4'h5, 3'h0, 0, 0, 1, 0);
        cp(1, 4'h5, 3'h0, rd ^ 32'hffff_ffff, 0, 1, 0);
        cp(0, 4'h5, 3'h0, 0, 0, 1, 0);
        chk("dfs_wr", 32'h0000_00d9, rd);
    endtask
    task automatic complete_run();
        $display("err_count %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        srst = 1; swd = 0; miss = '0; check = '0; abort_in = '0;
        repeat (8) @(posedge core_clk);
        #1 srst = 0;
        t_select(); t_domain(); t_secure(); t_abort();
        complete_run();
    end
    // Watchdog well past the roughly 75 cycles needed
    initial begin repeat (3000) @(posedge core_clk); err_count++; complete_run(); end
endmodule
